// *** umlsc_pkg.sv ***
package umlsc_pkg;
    localparam int         CLK_HZ      = 100_000_000;
    localparam int         MAX_BAUD    = 3_000_000;
    localparam int         SAMP_MIN    = (CLK_HZ + MAX_BAUD - 1) / MAX_BAUD;
    localparam int         BRK_TX      = 13;
    localparam int         BRK_DET     = 11;
    localparam int         BRK_REQ_BIT = 16;
    localparam logic [3:0] WID_MIN     = 4'h4;
    localparam logic [3:0] WID_MAX     = 4'h9;
    localparam logic [3:0] HALF_MIN    = 4'h2;
    localparam logic [3:0] HALF_MAX    = 4'h8;
    localparam logic [7:0] SYNC_VAL    = 8'h55;
    localparam logic [5:0] ID_SIG_MAX  = 6'h3b;
    localparam logic [5:0] ID_DIAG_MAX = 6'h3d;
    localparam logic [3:0] LIN_FIELDS  = 4'h9;
    localparam logic [7:0] CHK_GOOD    = 8'hff;
    localparam logic [1:0] FC_SIG      = 2'h0;
    localparam logic [1:0] FC_DIAG     = 2'h1;
    localparam logic [1:0] FC_RSVD     = 2'h2;
    localparam logic [7:0] A_BLOCK_CONTROL = 8'h00;
    localparam logic [7:0] A_OVERSAMPLE    = 8'h04;
    localparam logic [7:0] A_OWN_ADDR_MASK = 8'h08;
    localparam logic [7:0] A_TX_DATA       = 8'h0c;
    localparam logic [7:0] A_RX_DATA       = 8'h10;
    localparam logic [7:0] A_STATUS        = 8'h14;
    localparam logic [7:0] A_LIN           = 8'h18;
    localparam logic [31:0] STAT_W1C       = 32'h0000_01fc;

    typedef struct packed {
        logic [13:0] pad;
        logic        autobaud;
        logic        enhanced;
        logic        lin;
        logic        accept;
        logic        addressing_slave_enable;
        logic        multi_drop_addressing_mode;
        logic        majority;
        logic        irda;
        logic        par_odd;
        logic        par_en;
        logic [3:0]  stop_halves;
        logic [3:0]  width;
    } umlsc_ctrl_type;

    localparam umlsc_ctrl_type CTRL_RST = '{stop_halves: 4'h2, width: 4'h8, default: '0};

    typedef struct packed {
        logic [22:0] pad;
        logic        overrun;
        logic        prot_id_err;
        logic        sync_err;
        logic        brk;
        logic        coll;
        logic        frm_err;
        logic        par_err;
        logic        tx_busy;
        logic        rx_valid;
    } umlsc_stat_type;

    typedef struct packed {
        logic [8:0] pad;
        logic       chk_ok;
        logic [1:0] fclass;
        logic [3:0] count;
        logic [7:0] checksum;
        logic [7:0] prot_id;
    } umlsc_lin_rd_type;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } umlsc_ahb_req_type;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } umlsc_ahb_rsp_type;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} umlsc_tx_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} umlsc_rx_type;
    typedef enum logic [1:0] {LN_IDLE, LN_SYNC, LN_ID, LN_DATA} umlsc_lin_type;
endpackage

// *** umlsc_core.sv ***
// Operation
// - data field defaults to eight bits, programmable 4 to 9
// - stop period in half-bit steps, one to four bits
// - optional even or odd parity bit after the data
// - infrared variant forces parity off
// - start bit is 0, stop bits are 1
// - transmit line idles at 1
// - receiver restarts bit timing on a falling edge while idle, i.e. at each start bit
// - bit value taken from the middle oversample
// - optional majority of three samples around the middle
// - multi-drop mode uses 9-bit data, bit 8 marks address
// - multi-drop mode sends and checks no parity
// - slave compares address with own address under mask
// - matching address stored only when accept is set
// - after a mismatch, data is dropped until next address
// - sync byte 0x55 follows break, may set bit rate
// - identifier in bits 0-5, parity in bits 6 and 7
// - ids to 0x3b signal, 0x3c-0x3d diagnostic, rest reserved
// - response of one to eight bytes, then checksum
// - checksum is inverted 8-bit sum with carries folded
// - classic sums data only, enhanced adds identifier
// - in LIN mode, flag collision when a driven bit other than a stop bit differs from line
// - bit rate limited to 3 Mbps
// - oversample factor counts internal clock cycles
module umlsc_core
    import umlsc_pkg::*;
#(
    parameter int SAMP_W   = 16,
    parameter int SAMP_DEF = 868
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire umlsc_ahb_req_type ahb_req,
    output umlsc_ahb_rsp_type      ahb_rsp,
    input  wire logic              rxd,
    output logic                   txd
);
    if (SAMP_W < 8 || SAMP_W > 24 || SAMP_DEF < SAMP_MIN || SAMP_DEF >= (1 << SAMP_W)) begin : g_chk
        $error("umlsc_core: oversample parameters out of range");
    end

    typedef struct packed {
        logic               rx_meta;
        logic               rx_sync;
        logic               rx_prev;
        umlsc_ctrl_type     ctrl;
        logic [SAMP_W-1:0]  bit_cyc;
        logic [7:0]         own_addr;
        logic [7:0]         addr_mask;
        umlsc_stat_type     stat;
        logic               a_act;
        logic               a_wr;
        logic [7:0]         a_addr;
        logic [31:0]        hrdata;
        umlsc_tx_type       tst;
        logic [SAMP_W-1:0]  tcnt;
        logic [3:0]         tbit;
        logic [8:0]         tsh;
        logic               txd;
        umlsc_rx_type       rxs;
        logic [SAMP_W-1:0]  rcnt;
        logic [3:0]         rbit;
        logic [8:0]         rsh;
        logic [1:0]         early;
        logic               perr;
        logic [8:0]         rdata;
        logic               matched;
        logic [SAMP_W+3:0]  lowcnt;
        umlsc_lin_type      lph;
        logic [7:0]         prot_id;
        logic [7:0]         acc;
        logic [3:0]         lcnt;
        logic [2:0]         falls;
        logic [SAMP_W+2:0]  abcnt;
    } umlsc_state_type;

    localparam umlsc_state_type S_RST = '{ctrl: CTRL_RST, bit_cyc: SAMP_W'(SAMP_DEF),
        rx_meta: 1'b1, rx_sync: 1'b1, rx_prev: 1'b1, txd: 1'b1,
        tst: TX_IDLE, rxs: RX_IDLE, lph: LN_IDLE, default: '0};

    function automatic logic [7:0] add_carry(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h0, s[8]};
    endfunction

    function automatic logic [7:0] lin_prot_id(input logic [5:0] id);
        return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction

    function automatic logic [1:0] lin_class(input logic [5:0] id);
        return (id <= ID_SIG_MAX) ? FC_SIG : (id <= ID_DIAG_MAX) ? FC_DIAG : FC_RSVD;
    endfunction

    function automatic logic char_par(input logic [8:0] d, input logic [3:0] w,
                                      input logic odd);
        return ^(d & ~(9'h1ff << w)) ^ odd;
    endfunction

    umlsc_state_type   s_r;
    umlsc_state_type   s_nxt;
    umlsc_lin_rd_type  lin_rd;
    logic [SAMP_W-1:0] half;
    logic [SAMP_W-1:0] dp;
    logic [SAMP_W-1:0] wdat;
    logic [SAMP_W+3:0] brk_lim;
    logic [3:0]        wid;
    logic              p_on;
    logic              mpm;
    logic              tick;
    logic              take;
    logic              vote;
    logic              rx_fall;
    logic              hit;
    logic              keep;

    always_comb begin
        s_nxt   = s_r;
        mpm     = s_r.ctrl.multi_drop_addressing_mode;
        p_on    = s_r.ctrl.par_en & ~s_r.ctrl.irda & ~mpm;
        wid     = mpm ? WID_MAX : s_r.ctrl.width;
        half    = s_r.bit_cyc >> 1;
        dp      = s_r.ctrl.majority ? half + 1'b1 : half;
        wdat    = ahb_req.hwdata[SAMP_W-1:0];
        brk_lim = (SAMP_W+4)'(s_r.bit_cyc) * (SAMP_W+4)'(BRK_DET);
        rx_fall = s_r.rx_prev & ~s_r.rx_sync;
        hit     = 1'b0;
        keep    = 1'b1;
        lin_rd  = '{pad: '0, chk_ok: (s_r.acc == CHK_GOOD) && (s_r.lcnt > 4'h1),
                    fclass: lin_class(s_r.prot_id[5:0]), count: s_r.lcnt,
                    checksum: ~s_r.acc, prot_id: s_r.prot_id};

        // only the second stage and the edge history look at the line
        s_nxt.rx_meta = rxd;
        s_nxt.rx_sync = s_r.rx_meta;
        s_nxt.rx_prev = s_r.rx_sync;

        // address phase: read data is latched here, so reads have no wait state
        s_nxt.a_act  = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
        s_nxt.a_wr   = ahb_req.hwrite;
        s_nxt.a_addr = ahb_req.haddr[7:0];
        if (s_nxt.a_act && !ahb_req.hwrite) begin
            case (ahb_req.haddr[7:0])
                A_BLOCK_CONTROL: s_nxt.hrdata = s_r.ctrl;
                A_OVERSAMPLE:    s_nxt.hrdata = 32'(s_r.bit_cyc);
                A_OWN_ADDR_MASK: s_nxt.hrdata = {16'h0, s_r.addr_mask, s_r.own_addr};
                A_RX_DATA: begin
                    s_nxt.hrdata         = {23'h0, s_r.rdata};
                    s_nxt.stat.rx_valid  = 1'b0;
                end
                A_STATUS:        s_nxt.hrdata = s_r.stat;
                A_LIN:           s_nxt.hrdata = lin_rd;
                default:         s_nxt.hrdata = 32'h0;
            endcase
        end

        if (s_r.a_act && s_r.a_wr) begin
            case (s_r.a_addr)
                A_BLOCK_CONTROL: begin
                    s_nxt.ctrl     = umlsc_ctrl_type'(ahb_req.hwdata);
                    s_nxt.ctrl.pad = '0;
                    if (s_nxt.ctrl.width < WID_MIN) s_nxt.ctrl.width = WID_MIN;
                    if (s_nxt.ctrl.width > WID_MAX) s_nxt.ctrl.width = WID_MAX;
                    if (s_nxt.ctrl.stop_halves < HALF_MIN) begin
                        s_nxt.ctrl.stop_halves = HALF_MIN;
                    end
                    if (s_nxt.ctrl.stop_halves > HALF_MAX) begin
                        s_nxt.ctrl.stop_halves = HALF_MAX;
                    end
                end
                A_OVERSAMPLE: begin
                    // writes below the rate limit clamp rather than fault
                    s_nxt.bit_cyc = (wdat < SAMP_W'(SAMP_MIN)) ? SAMP_W'(SAMP_MIN)
                                                               : wdat;
                end
                A_OWN_ADDR_MASK: {s_nxt.addr_mask, s_nxt.own_addr} = ahb_req.hwdata[15:0];
                A_TX_DATA: begin
                    // a write while a character is in flight is dropped; poll tx_busy
                    if (s_r.tst == TX_IDLE) begin
                        s_nxt.tsh  = ahb_req.hwdata[8:0];
                        s_nxt.tcnt = '0;
                        s_nxt.tbit = '0;
                        s_nxt.tst  = ahb_req.hwdata[BRK_REQ_BIT] ? TX_BRK : TX_START;
                    end
                end
                // from s_nxt so a pipelined data read that clears rx_valid is kept
                A_STATUS: s_nxt.stat = s_nxt.stat & ~(ahb_req.hwdata & STAT_W1C);
                A_LIN: begin
                    // seed for a response this node sends; the line loops back into rx
                    s_nxt.prot_id = lin_prot_id(ahb_req.hwdata[5:0]);
                    s_nxt.acc     = s_r.ctrl.enhanced ? s_nxt.prot_id : 8'h0;
                    s_nxt.lcnt    = '0;
                    s_nxt.lph     = LN_DATA;
                end
                default: ;
            endcase
        end

        // transmitter: bit period counted in hclk cycles, stop counted in halves
        tick = (s_r.tst == TX_STOP) ? (s_r.tcnt == half - 1'b1)
                                    : (s_r.tcnt == s_r.bit_cyc - 1'b1);
        if (s_r.tst != TX_IDLE) begin
            s_nxt.tcnt = tick ? '0 : s_r.tcnt + 1'b1;
            if (s_r.ctrl.lin && s_r.tcnt == half && s_r.rx_sync != s_r.txd) begin
                s_nxt.stat.coll = 1'b1;
            end
        end
        case (s_r.tst)
            TX_DATA: begin
                if (tick) begin
                    s_nxt.tbit = s_r.tbit + 1'b1;
                    if (s_r.tbit == wid - 1'b1) begin
                        s_nxt.tbit = '0;
                        s_nxt.tst  = p_on ? TX_PAR : TX_STOP;
                    end
                end
            end
            TX_START: if (tick) s_nxt.tst = TX_DATA;
            TX_PAR:   if (tick) s_nxt.tst = TX_STOP;
            TX_STOP: begin
                if (tick) begin
                    s_nxt.tbit = s_r.tbit + 1'b1;
                    if (s_r.tbit >= s_r.ctrl.stop_halves - 1'b1) begin
                        s_nxt.tbit = '0;
                        s_nxt.tst  = TX_IDLE;
                    end
                end
            end
            TX_BRK: begin
                if (tick) begin
                    s_nxt.tbit = s_r.tbit + 1'b1;
                    if (s_r.tbit == 4'(BRK_TX - 1)) begin
                        s_nxt.tbit = '0;
                        s_nxt.tst  = TX_STOP;
                    end
                end
            end
            default: ;
        endcase
        case (s_nxt.tst)
            TX_START: s_nxt.txd = 1'b0;
            TX_DATA:  s_nxt.txd = s_nxt.tsh[s_nxt.tbit];
            TX_PAR:   s_nxt.txd = char_par(s_nxt.tsh, wid, s_r.ctrl.par_odd);
            TX_BRK:   s_nxt.txd = 1'b0;
            default:  s_nxt.txd = 1'b1;
        endcase
        s_nxt.stat.tx_busy = s_nxt.tst != TX_IDLE;

        // receiver: samples one before and at the middle are kept for the vote
        if (s_r.rcnt == half - 1'b1) s_nxt.early[0] = s_r.rx_sync;
        if (s_r.rcnt == half) s_nxt.early[1] = s_r.rx_sync;
        vote = s_r.ctrl.majority ? (s_r.early[0] & s_r.early[1]) | (s_r.early[0] & s_r.rx_sync)
                                   | (s_r.early[1] & s_r.rx_sync) : s_r.rx_sync;
        take = (s_r.rxs != RX_IDLE) && (s_r.rcnt == dp);
        if (s_r.rxs != RX_IDLE) begin
            // >= so that an autobaud shrink mid-character cannot run away
            s_nxt.rcnt = (s_r.rcnt >= s_r.bit_cyc - 1'b1) ? '0 : s_r.rcnt + 1'b1;
        end
        case (s_r.rxs)
            RX_IDLE: begin
                if (rx_fall) begin
                    s_nxt.rxs  = RX_START;
                    s_nxt.rcnt = '0;
                    s_nxt.rbit = '0;
                    s_nxt.rsh  = '0;
                    s_nxt.perr = 1'b0;
                end
            end
            RX_START: if (take) s_nxt.rxs = vote ? RX_IDLE : RX_DATA;
            RX_DATA: begin
                if (take) begin
                    s_nxt.rsh[s_r.rbit] = vote;
                    s_nxt.rbit          = s_r.rbit + 1'b1;
                    if (s_r.rbit == wid - 1'b1) begin
                        s_nxt.rbit = '0;
                        s_nxt.rxs  = p_on ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (take) begin
                    s_nxt.perr = vote != char_par(s_r.rsh, wid, s_r.ctrl.par_odd);
                    s_nxt.rxs  = RX_STOP;
                end
            end
            RX_STOP: begin
                if (take) begin
                    s_nxt.rxs = RX_IDLE;
                    if (mpm && s_r.ctrl.addressing_slave_enable) begin
                        if (s_r.rsh[8]) begin
                            hit           = ((s_r.rsh[7:0] ^ s_r.own_addr) & s_r.addr_mask) == 8'h0;
                            s_nxt.matched = hit;
                            keep          = hit & s_r.ctrl.accept;
                        end else begin
                            keep = s_r.matched;
                        end
                    end
                    if (keep) begin
                        if (s_nxt.stat.rx_valid) begin
                            s_nxt.stat.overrun = 1'b1;
                        end else begin
                            s_nxt.rdata         = s_r.rsh;
                            s_nxt.stat.rx_valid = 1'b1;
                            s_nxt.stat.par_err  = s_nxt.stat.par_err | s_r.perr;
                            s_nxt.stat.frm_err  = s_nxt.stat.frm_err | ~vote;
                        end
                    end
                    if (s_r.ctrl.lin) begin
                        case (s_r.lph)
                            LN_SYNC: begin
                                if (s_r.rsh[7:0] != SYNC_VAL) s_nxt.stat.sync_err = 1'b1;
                                s_nxt.lph = LN_ID;
                            end
                            LN_ID: begin
                                s_nxt.prot_id = s_r.rsh[7:0];
                                if (s_r.rsh[7:0] != lin_prot_id(s_r.rsh[5:0])) begin
                                    s_nxt.stat.prot_id_err = 1'b1;
                                end
                                s_nxt.acc  = s_r.ctrl.enhanced ? s_r.rsh[7:0] : 8'h0;
                                s_nxt.lcnt = '0;
                                s_nxt.lph  = LN_DATA;
                            end
                            LN_DATA: begin
                                if (s_r.lcnt != LIN_FIELDS) begin
                                    s_nxt.acc  = add_carry(s_r.acc, s_r.rsh[7:0]);
                                    s_nxt.lcnt = s_r.lcnt + 1'b1;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            end
            default: s_nxt.rxs = RX_IDLE;
        endcase

        // break: detect at 11 bit times, short of the 13 a master must send
        if (s_r.rx_sync) begin
            s_nxt.lowcnt = '0;
        end else if (s_r.lowcnt != brk_lim) begin
            s_nxt.lowcnt = s_r.lowcnt + 1'b1;
            if (s_r.lowcnt == brk_lim - 1'b1 && s_r.ctrl.lin) begin
                s_nxt.stat.brk = 1'b1;
                s_nxt.lph      = LN_SYNC;
                s_nxt.falls    = '0;
            end
        end

        // autobaud: first to fifth falling edge of the sync byte spans 8 bits
        if (s_r.lph == LN_SYNC && s_r.falls != 3'h0 && s_r.falls != 3'h5) begin
            s_nxt.abcnt = s_r.abcnt + 1'b1;
        end
        if (s_r.lph == LN_SYNC && rx_fall && s_r.falls != 3'h5) begin
            s_nxt.falls = s_r.falls + 1'b1;
            if (s_r.falls == 3'h0) s_nxt.abcnt = (SAMP_W+3)'(1);
            if (s_r.falls == 3'h4 && s_r.ctrl.autobaud) begin
                s_nxt.bit_cyc = (s_r.abcnt[SAMP_W+2:3] < SAMP_W'(SAMP_MIN)) ? SAMP_W'(SAMP_MIN)
                            : s_r.abcnt[SAMP_W+2:3];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= S_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ahb_rsp = '{hrdata: s_r.hrdata, hreadyout: 1'b1, hresp: 1'b0};
    assign txd     = s_r.txd;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    idle_high_a: assert property (s_r.tst == TX_IDLE |-> txd)
        else $error("tx line not high while idle");
    start_low_a: assert property (s_r.tst == TX_START |-> !txd)
        else $error("start bit not low");
    stop_high_a: assert property (s_r.tst == TX_STOP |-> txd)
        else $error("stop bit not high");
    width_range_a: assert property (s_r.ctrl.width inside {[WID_MIN:WID_MAX]})
        else $error("data width out of range");
    stop_range_a: assert property (s_r.ctrl.stop_halves inside {[HALF_MIN:HALF_MAX]})
        else $error("stop length out of range");
    irda_nopar_a: assert property (s_r.ctrl.irda && s_r.tst == TX_DATA |=> s_r.tst != TX_PAR)
        else $error("parity sent in infrared mode");
    md_nopar_a: assert property (mpm && s_r.rxs == RX_DATA |=> s_r.rxs != RX_PAR)
        else $error("parity expected in multi-drop mode");
    resync_a: assert property (s_r.rxs == RX_IDLE && rx_fall
                               |=> s_r.rxs == RX_START && s_r.rcnt == '0)
        else $error("receiver did not restart on falling edge");
    rate_limit_a: assert property (s_r.bit_cyc >= SAMP_W'(SAMP_MIN))
        else $error("bit period below rate limit");
    collision_a: assert property (s_r.ctrl.lin && s_r.tst != TX_IDLE && s_r.tcnt == half
                                  && s_r.rx_sync != s_r.txd |=> s_r.stat.coll)
        else $error("collision not flagged");

    brk_cover_c: cover property (s_r.tst == TX_BRK ##1 s_r.tst == TX_STOP);
    rx_char_c: cover property ($rose(s_r.stat.rx_valid));
    lin_full_c: cover property (s_r.lph == LN_DATA && s_r.lcnt == LIN_FIELDS);
endmodule

// *** umlsc_peer.sv ***
module umlsc_peer #(
    parameter int BIT_CYC = 34
) (
    input  wire logic hclk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd = 1'b1;
    // par: 0 even, 1 odd, 2 none
    task automatic send(input logic [8:0] v, input int n, input int par);
        int i;
        rxd <= 1'b0;
        repeat (BIT_CYC) @(posedge hclk);
        for (i = 0; i < n; i++) begin
            rxd <= v[i];
            repeat (BIT_CYC) @(posedge hclk);
        end
        if (par < 2) begin
            rxd <= ^(v & ((9'h1 << n) - 9'h1)) ^ par[0];
            repeat (BIT_CYC) @(posedge hclk);
        end
        rxd <= 1'b1;
        repeat (2 * BIT_CYC) @(posedge hclk);
    endtask
    // frame opener of a bus master: 13 low bit times, then a delimiter
    task automatic brk();
        rxd <= 1'b0;
        repeat (13 * BIT_CYC) @(posedge hclk);
        rxd <= 1'b1;
        repeat (2 * BIT_CYC) @(posedge hclk);
    endtask
    // samples mid-bit, as a real receiver would
    task automatic recv(input int n, output logic [8:0] v, output logic stp);
        int i;
        v = '0;
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge hclk);
        for (i = 0; i < n; i++) begin
            repeat (BIT_CYC) @(posedge hclk);
            v[i] = txd;
        end
        repeat (BIT_CYC) @(posedge hclk);
        stp = txd;
    endtask
endmodule

// *** tb.sv ***
module tb
    import umlsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CYC = 34;
    logic              hclk, hresetn, hsel, hwrite, txd, rxd, stp;
    logic [31:0]       haddr, hwdata, q;
    logic [1:0]        htrans;
    logic [8:0]        v, v2;
    logic [8:0]        exp_q[$];
    umlsc_ahb_req_type req;
    umlsc_ahb_rsp_type rsp;
    int                mismatches, checks, i, s;
    assign req = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};
    umlsc_core #(.SAMP_DEF(BIT_CYC)) dut_u (.hclk(hclk), .hresetn(hresetn), .ahb_req(req),
        .ahb_rsp(rsp), .rxd(rxd), .txd(txd));
    umlsc_peer #(.BIT_CYC(BIT_CYC)) peer_u (.hclk(hclk), .txd(txd), .rxd(rxd));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (rsp.hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (rsp.hreadyout !== 1'b1) @(posedge hclk);
        q = rsp.hrdata;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #500_000;
        mismatches++;
        conclude;
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
        s = $urandom(32'h2ffc71e0);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(A_BLOCK_CONTROL, 32'h28);
        rd(A_OVERSAMPLE, 32'(BIT_CYC));
        rd(8'h1c, 32'h0);
        ahb(1'b1, A_OVERSAMPLE, 32'h5);
        rd(A_OVERSAMPLE, 32'd34);
        $display("registers done");
        // third pass selects the infrared variant: no parity despite par_en
        for (i = 0; i < 3; i++) begin
            ahb(1'b1, A_BLOCK_CONTROL, 32'h128 | (i << 9));
            v = 9'($urandom % 256);
            fork
                peer_u.recv(9, v2, stp);
                ahb(1'b1, A_TX_DATA, {23'h0, v});
            join
            chk({23'h0, v2}, {23'h0, (i == 2) | (^v[7:0] ^ i[0]), v[7:0]});
            chk({31'h0, stp}, 32'h1);
            repeat (2 * BIT_CYC) @(posedge hclk);
        end
        $display("transmit done");
        ahb(1'b1, A_BLOCK_CONTROL, 32'h928);
        for (i = 0; i < 2; i++) begin
            v = 9'($urandom % 256);
            exp_q.push_back(v);
            peer_u.send(v, 8, i);
            rd(A_STATUS, 32'h1 | (i << 2));
            rd(A_RX_DATA, {23'h0, exp_q.pop_front()});
            ahb(1'b1, A_STATUS, 32'h1fc);
        end
        $display("receive done");
        ahb(1'b1, A_OWN_ADDR_MASK, 32'hff12);
        ahb(1'b1, A_BLOCK_CONTROL, 32'h3029);
        peer_u.send(9'h112, 9, 2);
        peer_u.send(9'h0aa, 9, 2);
        rd(A_STATUS, 32'h1);
        rd(A_RX_DATA, 32'haa);
        peer_u.send(9'h113, 9, 2);
        peer_u.send(9'h055, 9, 2);
        rd(A_STATUS, 32'h0);
        ahb(1'b1, A_BLOCK_CONTROL, 32'h7029);
        ahb(1'b1, A_OWN_ADDR_MASK, 32'hfe12);
        peer_u.send(9'h113, 9, 2);
        rd(A_RX_DATA, 32'h113);
        $display("multi-drop done");
        ahb(1'b1, A_BLOCK_CONTROL, 32'h38028);
        ahb(1'b1, A_LIN, 32'h10);
        rd(A_LIN, 32'h0000af50);
        ahb(1'b1, A_TX_DATA, 32'h10000);
        repeat (12 * BIT_CYC) @(posedge hclk);
        chk({31'h0, txd}, 32'h0);
        repeat (3 * BIT_CYC) @(posedge hclk);
        rd(A_STATUS, 32'h10);
        ahb(1'b1, A_STATUS, 32'h1fc);
        peer_u.brk();
        rd(A_STATUS, 32'h29);
        rd(A_RX_DATA, 32'h0);
        ahb(1'b1, A_STATUS, 32'h1fc);
        peer_u.send(9'h055, 8, 2);
        rd(A_RX_DATA, 32'h55);
        peer_u.send(9'h050, 8, 2);
        rd(A_STATUS, 32'h1);
        rd(A_RX_DATA, 32'h50);
        rd(A_OVERSAMPLE, 32'(BIT_CYC));
        $display("header done");
        s = 'h50;
        for (i = 0; i < 3; i++) begin
            v = 9'($urandom % 256);
            s = s + v;
            s = (s & 255) + (s >> 8);
            peer_u.send(v, 8, 2);
            ahb(1'b0, A_RX_DATA, 32'h0);
        end
        peer_u.send(9'(~s & 255), 8, 2);
        ahb(1'b0, A_LIN, 32'h0);
        chk(q & 32'h007f00ff, 32'h00440050);
        $display("checksum done");
        conclude;
    end
endmodule
